// ### bench/mbd_diag_handler_assertions.sv
// mbd_diag_handler_assertions.sv: port-level checks on the handler.
// assumes: bound to mbd_diag_handler, one clock, srst sync high.
`timescale 1ns/1ps
module mbd_diag_handler_assertions
#(
  parameter CNT_W = 16
)
(
  input logic clock,
  input logic srst,
  input logic reqValid,
  input logic [7:0] reqFunc,
  input logic [15:0] reqSubCode,
  input logic [15:0] reqData,
  input logic rspValid,
  input logic rspException,
  input logic [15:0] rspData,
  input logic [3:0] rspExcCode,
  input logic rspSuppressed,
  input logic [7:0] asciiDelim,
  input logic [15:0] diagReg,
  input logic mstValid,
  input logic mstIsWrite,
  input logic mstWriteEnabled,
  input logic mstTimeout,
  input logic [3:0] mstWriteErr,
  input logic [3:0] mstReadErr
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  wire lo = diagReg[5];
  wire dg = reqValid && reqFunc == 8'h08 && !lo;
  wire [15:0] sc = reqSubCode;
  // ----
  // properties
  // ----
  property p_echo;
    dg && sc == 16'h0000 |=> rspValid && rspData == $past(reqData);
  endproperty
  a_echo: assert property (p_echo) else $error("echo bad");
  property p_zero;
    dg && (sc == 16'h0002 || sc == 16'h0010 || sc == 16'h0011)
      |=> rspValid && rspData == 16'h0000;
  endproperty
  a_zero: assert property (p_zero) else $error("zero bad");
  property p_delim;
    dg && sc == 16'h0003 |=> asciiDelim == $past(reqData[15:8]);
  endproperty
  a_delim: assert property (p_delim) else $error("delim bad");
  property p_listen;
    dg && sc == 16'h0004 && reqData == 16'h0000
      |=> !rspValid ##1 diagReg[5];
  endproperty
  a_listen: assert property (p_listen) else $error("listen bad");
  property p_func;
    reqValid && !lo && reqFunc == 8'h07 |=> rspExcCode == 4'h1;
  endproperty
  a_func: assert property (p_func) else $error("func bad");
  property p_codes;
    rspValid && rspException |-> rspExcCode inside {1, 2, 3, 8};
  endproperty
  a_codes: assert property (p_codes) else $error("code bad");
  property p_silent;
    reqValid && lo && sc != 16'h0001 |=> !rspValid && rspSuppressed;
  endproperty
  a_silent: assert property (p_silent) else $error("silent bad");
  property p_wrinh;
    mstValid && mstIsWrite && !mstWriteEnabled |=> mstWriteErr == 4'hd;
  endproperty
  a_wrinh: assert property (p_wrinh) else $error("0d bad");
  property p_tmo;
    mstValid && !mstIsWrite && mstTimeout |=> mstReadErr == 4'hf;
  endproperty
  a_tmo: assert property (p_tmo) else $error("0f bad");
  c_exc: cover property (rspValid && rspException);
  c_lo: cover property (lo);
  c_tmo: cover property (mstValid && mstTimeout);
endmodule
bind mbd_diag_handler mbd_diag_handler_assertions #(.CNT_W(CNT_W)) chk (
  .clock(clock), .srst(srst), .reqValid(reqValid), .reqFunc(reqFunc),
  .reqSubCode(reqSubCode), .reqData(reqData), .rspValid(rspValid),
  .rspException(rspException), .rspData(rspData),
  .rspExcCode(rspExcCode), .rspSuppressed(rspSuppressed),
  .asciiDelim(asciiDelim), .diagReg(diagReg), .mstValid(mstValid),
  .mstIsWrite(mstIsWrite), .mstWriteEnabled(mstWriteEnabled),
  .mstTimeout(mstTimeout), .mstWriteErr(mstWriteErr),
  .mstReadErr(mstReadErr));

// ### bench/mbd_diag_handler_tb.sv
// mbd_diag_handler_tb.sv: self-checking bench for the handler.
// assumes: mbd_master_model stands in for the polling master.
`timescale 1ns/1ps
module mbd_diag_handler_tb;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic singleRange = 1'b0;
  logic mstValid = 1'b0;
  logic mstIsWrite = 1'b0;
  logic mstWriteEnabled = 1'b0;
  logic mstGotException = 1'b0;
  logic [3:0] mstExcCode = 4'h0;
  logic mstLengthBad = 1'b0;
  logic mstTimeout = 1'b0;
  logic reqValid, rspValid, rspException, rspSuppressed, restartPulse;
  logic [2:0] ok;
  logic [3:0] ev, rspExcCode, mstWriteErr, mstReadErr;
  logic [7:0] reqFunc, rspFunc, asciiDelim;
  logic [15:0] reqSubCode, reqData, rspData, diagReg;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  initial
  begin
    forever #10 clock = ~clock;
  end
  mbd_master_model m (.clock(clock), .reqValid(reqValid),
    .reqFunc(reqFunc), .reqSubCode(reqSubCode), .reqData(reqData),
    .ok(ok), .ev(ev));
  mbd_diag_handler #(.CNT_W(16)) uut (.clock(clock), .srst(srst),
    .reqValid(reqValid), .reqFunc(reqFunc), .reqSubCode(reqSubCode),
    .reqData(reqData), .reqAddrOk(ok[2]), .reqValueOk(ok[1]),
    .reqWriteDisabled(ok[0]), .singleRange(singleRange),
    .evCrcError(ev[0]), .evGoodMsg(ev[1]), .evCharError(ev[2]),
    .evBufferFail(ev[3]), .rspValid(rspValid),
    .rspException(rspException), .rspFunc(rspFunc), .rspData(rspData),
    .rspExcCode(rspExcCode), .rspSuppressed(rspSuppressed),
    .restartPulse(restartPulse), .asciiDelim(asciiDelim),
    .diagReg(diagReg), .mstValid(mstValid), .mstIsWrite(mstIsWrite),
    .mstWriteEnabled(mstWriteEnabled), .mstGotException(mstGotException),
    .mstExcCode(mstExcCode), .mstLengthBad(mstLengthBad),
    .mstTimeout(mstTimeout), .mstWriteErr(mstWriteErr),
    .mstReadErr(mstReadErr));
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, ex);
    total_checks++;
    if (got !== ex)
    begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, ex, got);
    end
  endtask
  // valid answer, exception flag and code, and data when no exception
  task automatic rsp(input string nm, input logic [3:0] c,
    input logic [15:0] d);
    chk(nm, {10'h0, rspValid, rspException, rspExcCode},
      {10'h0, 1'b1, c != 4'h0, c});
    if (c == 4'h0)
      chk(nm, rspData, d);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_echo();
    logic [15:0] zs [3] = '{16'h0002, 16'h0010, 16'h0011};
    chk("delim0", {8'h0, asciiDelim}, 16'h000a);
    m.send(8'h08, 16'h0000, 16'h1234, 3'b110);
    rsp("echo", 4'h0, 16'h1234);
    chk("func", {8'h0, rspFunc}, 16'h0008);
    m.send(8'h08, 16'h0003, 16'hab12, 3'b110);
    rsp("delim", 4'h0, 16'hab12);
    chk("delim", {8'h0, asciiDelim}, 16'h00ab);
    foreach (zs[i])
    begin
      m.send(8'h08, zs[i], 16'h5555, 3'b110);
      rsp("zero", 4'h0, 16'h0000);
    end
  endtask
  task automatic t_exc();
    logic [15:0] bad [3] = '{16'h000b, 16'h0013, 16'h0014};
    logic [7:0] wr [4] = '{8'h05, 8'h0f, 8'h06, 8'h10};
    logic [7:0] rd [4] = '{8'h01, 8'h02, 8'h03, 8'h04};
    logic [15:0] bv [3] = '{16'h0001, 16'h0004, 16'h000a};
    m.send(8'h07, 16'h0000, 16'h0000, 3'b110);
    rsp("func", 4'h1, 16'h0);
    foreach (bad[i])
    begin
      m.send(8'h08, bad[i], 16'h0000, 3'b110);
      rsp("sub", 4'h1, 16'h0);
    end
    m.send(8'h03, 16'h0000, 16'h0000, 3'b010);
    rsp("addr", 4'h2, 16'h0);
    m.send(8'h03, 16'h0000, 16'h0000, 3'b100);
    rsp("value", 4'h3, 16'h0);
    foreach (bv[i])
    begin
      m.send(8'h08, bv[i], 16'h0001, 3'b110);
      rsp("badval", 4'h3, 16'h0);
    end
    foreach (wr[i])
    begin
      m.send(wr[i], 16'h0000, 16'h0000, 3'b111);
      rsp("wrprot", 4'h8, 16'h0);
    end
    foreach (rd[i])
    begin
      m.send(rd[i], 16'h0000, 16'h0000, 3'b111);
      chk("read", {14'h0, rspValid, rspException}, 16'h2);
    end
    singleRange <= 1'b1;
    m.send(8'h02, 16'h0000, 16'h0000, 3'b111);
    chk("single", {15'h0, rspException}, 16'h0);
    singleRange <= 1'b0;
  endtask
  task automatic t_count();
    logic [15:0] sub [5] = '{16'h000c, 16'h000e, 16'h0012, 16'h000d,
      16'h000f};
    logic [15:0] ex [5] = '{16'h3, 16'h2, 16'h4, 16'h1, 16'h2};
    m.send(8'h08, 16'h000a, 16'h0000, 3'b110);
    rsp("clear", 4'h0, 16'h0000);
    m.pulse(0, 3);
    m.pulse(1, 2);
    m.pulse(2, 4);
    m.pulse(3, 1);
    m.send(8'h07, 16'h0000, 16'h0000, 3'b110);
    repeat (2) @(posedge clock);
    foreach (sub[i])
    begin
      m.send(8'h08, sub[i], 16'h0000, 3'b110);
      rsp("count", 4'h0, ex[i]);
    end
  endtask
  task automatic t_listen();
    m.send(8'h08, 16'h0004, 16'h0000, 3'b110);
    chk("quiet", {14'h0, rspValid, rspSuppressed}, 16'h1);
    @(posedge clock);
    #1;
    chk("lobit", diagReg, 16'h0020);
    m.send(8'h08, 16'h0000, 16'h4321, 3'b110);
    chk("lo echo", {14'h0, rspValid, rspSuppressed}, 16'h1);
    m.send(8'h07, 16'h0000, 16'h0000, 3'b110);
    chk("lo exc", {14'h0, rspValid, rspSuppressed}, 16'h1);
    m.send(8'h08, 16'h0001, 16'h0000, 3'b110);
    chk("rst0", {14'h0, rspValid, restartPulse}, 16'h3);
    chk("rst0 lo", diagReg, 16'h0020);
    m.send(8'h08, 16'h0001, 16'hff00, 3'b110);
    chk("restart", {14'h0, rspValid, restartPulse}, 16'h3);
    @(posedge clock);
    #1;
    chk("lo off", diagReg, 16'h0000);
  endtask
  task automatic mx(input logic w, en, ge, lb, to, input logic [3:0] c);
    @(posedge clock);
    mstValid <= 1'b1;
    {mstIsWrite, mstWriteEnabled, mstGotException} <= {w, en, ge};
    {mstLengthBad, mstTimeout, mstExcCode} <= {lb, to, c};
    @(posedge clock);
    mstValid <= 1'b0;
    #1;
  endtask
  task automatic t_master();
    mx(1, 0, 0, 0, 0, 4'h0);
    chk("wr 0d", {12'h0, mstWriteErr}, 16'hd);
    mx(0, 1, 0, 0, 1, 4'h0);
    chk("rd 0f", {12'h0, mstReadErr}, 16'hf);
    chk("wr held", {12'h0, mstWriteErr}, 16'hd);
    mx(0, 1, 0, 1, 0, 4'h0);
    chk("rd 0e", {12'h0, mstReadErr}, 16'he);
    mx(0, 1, 1, 0, 0, 4'h2);
    chk("rd exc", {12'h0, mstReadErr}, 16'h2);
    mx(1, 1, 1, 0, 0, 4'h8);
    chk("wr exc", {12'h0, mstWriteErr}, 16'h8);
    mx(0, 1, 0, 0, 0, 4'h0);
    chk("rd ok", {12'h0, mstReadErr}, 16'h0);
  endtask
  // mid-run reset must drop listen-only, delimiter and counts
  task automatic t_reset();
    m.send(8'h08, 16'h0003, 16'h5a00, 3'b110);
    m.pulse(0, 2);
    m.send(8'h08, 16'h0004, 16'h0000, 3'b110);
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
    chk("rst lo", diagReg, 16'h0000);
    chk("rst delim", {8'h0, asciiDelim}, 16'h000a);
    m.send(8'h08, 16'h000c, 16'h0000, 3'b110);
    rsp("rst cnt", 4'h0, 16'h0000);
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_echo();
    t_exc();
    t_count();
    t_listen();
    t_master();
    t_reset();
    test_done();
  end
endmodule

// ### bench/mbd_master_model.sv
// mbd_master_model.sv: polling master framing requests and link events.
// assumes: shares the handler's clock.
`timescale 1ns/1ps
module mbd_master_model
(
  input logic clock,
  output logic reqValid,
  output logic [7:0] reqFunc,
  output logic [15:0] reqSubCode,
  output logic [15:0] reqData,
  output logic [2:0] ok,
  output logic [3:0] ev
);
  initial
  begin
    reqValid = 1'b0;
    reqFunc = 8'h00;
    reqSubCode = 16'h0000;
    reqData = 16'h0000;
    ok = 3'b110;
    ev = 4'h0;
  end
  // ----
  // request and event tasks
  // ----
  task automatic send(input logic [7:0] f, input logic [15:0] s, d,
    input logic [2:0] k);
    @(posedge clock);
    reqValid <= 1'b1;
    reqFunc <= f;
    reqSubCode <= s;
    reqData <= d;
    ok <= k;
    @(posedge clock);
    reqValid <= 1'b0;
    // sub-code and data scrambled once released, so neither stale field is trusted
    reqSubCode <= ~s;
    reqData <= ~d;
    #1;
  endtask
  task automatic pulse(input int k, input int n);
    repeat (n)
    begin
      @(posedge clock);
      ev[k] <= 1'b1;
      @(posedge clock);
      ev[k] <= 1'b0;
    end
  endtask
endmodule

// ### verilog/mbd_consts.vh
// mbd_consts.vh: codes, field positions and reset values for the
// serial-protocol diagnostic and exception handler.
// assumes: included by bare name from the design files.
`ifndef MBD_CONSTS_VH
`define MBD_CONSTS_VH

// ----------------------------------------
// function codes
// ----------------------------------------
`define MBD_FC_RD_OBITS 8'h01
`define MBD_FC_RD_IBITS 8'h02
`define MBD_FC_RD_OREGS 8'h03
`define MBD_FC_RD_IREGS 8'h04
`define MBD_FC_WR_OBIT 8'h05
`define MBD_FC_WR_OREG 8'h06
`define MBD_FC_DIAG 8'h08
`define MBD_FC_WR_OBITS 8'h0f
`define MBD_FC_WR_OREGS 8'h10

// ----------------------------------------
// diagnostic sub-codes and data values
// ----------------------------------------
`define MBD_SUB_ECHO 16'h0000
`define MBD_SUB_RESTART 16'h0001
`define MBD_SUB_DIAGREG 16'h0002
`define MBD_SUB_DELIM 16'h0003
`define MBD_SUB_LISTEN 16'h0004
`define MBD_SUB_CLRCNT 16'h000a
`define MBD_SUB_CRCCNT 16'h000c
`define MBD_SUB_EXCCNT 16'h000d
`define MBD_SUB_MSGCNT 16'h000e
`define MBD_SUB_NORSP 16'h000f
`define MBD_SUB_ZERO0 16'h0010
`define MBD_SUB_ZERO1 16'h0011
`define MBD_SUB_CHARERR 16'h0012
`define MBD_DATA_ZERO 16'h0000
`define MBD_DATA_CLRLO 16'hff00

// ----------------------------------------
// exception and master error codes
// ----------------------------------------
`define MBD_EX_NONE 4'h0
`define MBD_EX_FUNC 4'h1
`define MBD_EX_ADDR 4'h2
`define MBD_EX_VALUE 4'h3
`define MBD_EX_WRPROT 4'h8
`define MBD_ME_WRINH 4'hd
`define MBD_ME_LENGTH 4'he
`define MBD_ME_TIMEOUT 4'hf

// ----------------------------------------
// register fields and reset values
// ----------------------------------------
`define MBD_DREG_LISTEN_BIT 5
`define MBD_WERR_LSB 8
`define MBD_RERR_LSB 12
`define MBD_DELIM_RST 8'h0a
`define MBD_CNT_W 16

`endif

// ### verilog/mbd_counter.v
// mbd_counter.v: one saturating diagnostic event counter.
// assumes: count and clear are single-cycle pulses on clock.
`timescale 1ns/1ps
`include "mbd_consts.vh"

module mbd_counter
#(
  parameter WIDTH = `MBD_CNT_W
)
(
  input wire clock,
  input wire srst,
  input wire clear,
  input wire count,
  output wire [WIDTH-1:0] value
);

  reg [WIDTH-1:0] value_q;
  reg [WIDTH-1:0] value_d;

  // an event in the clear cycle counts as the first after it
  always @*
  begin
    value_d = value_q;
    if (clear)
      value_d = {WIDTH{1'b0}};
    if (count && (clear || value_q != {WIDTH{1'b1}}))
      value_d = value_d + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  always @(posedge clock)
  begin
    if (srst)
      value_q <= {WIDTH{1'b0}};
    else
      value_q <= value_d;
  end

  assign value = value_q;

endmodule

// ### verilog/mbd_diag_handler.v
// mbd_diag_handler.v: diagnostic sub-code interpreter, slave exception
// generator and master error recorder for a serial protocol link.
// assumes: a framer on the same clock delivers decoded requests and
// link events as single-cycle pulses, and sends what this answers.
//
// Overview of operation
// - function 8 carries a 16-bit sub-code then a 16-bit data field.
// - sub-code 0000 echoes the request data unchanged.
// - 0001/0000 restarts; 0001/FF00 also clears counters, ends listen.
// - sub-codes 0002, 0010 and 0011 answer with data zero.
// - sub-code 0003 takes upper data byte as delimiter and echoes.
// - sub-code 0004/0000 enters listen-only mode and sends nothing.
// - sub-code 000C returns count of CRC errors addressed to us.
// - sub-code 000D returns count of exception responses sent.
// - sub-code 000E returns count of good messages addressed to us.
// - sub-code 000F returns count of lost messages plus exception 01 answers sent.
// - sub-code 0012 returns overrun plus parity plus framing errors.
// - illegal function gives exception 01; 000B, 0013, 0014 unsupported.
// - a nonexistent address gives exception 02.
// - an invalid data value gives exception 03.
// - a write to a write-disabled table gives exception 08.
// - as slave only exception codes 01, 02, 03 and 08 appear.
// - as master a slave's exception code goes into mstWriteErr or mstReadErr.
// - as master a write with no write code enabled records 0D.
// - as master a wrong response length records 0E.
// - as master a response timeout records 0F.
// - separate tables: 01/05/15 out bits, 02 in bits, 03/06/16, 04.
// - single range: codes 01 and 02 alike, 03 and 04 alike.
// - diagnostic register bit 5 shows listen-only mode.
`timescale 1ns/1ps
`include "mbd_consts.vh"

module mbd_diag_handler
#(
  parameter CNT_W = `MBD_CNT_W
)
(
  input wire clock,
  input wire srst,
  // ----- slave request side -----
  input wire reqValid,
  input wire [7:0] reqFunc,
  input wire [15:0] reqSubCode,
  input wire [15:0] reqData,
  input wire reqAddrOk,
  input wire reqValueOk,
  input wire reqWriteDisabled,
  input wire singleRange,
  // ----- link events from the framer -----
  input wire evCrcError,
  input wire evGoodMsg,
  input wire evCharError,
  input wire evBufferFail,
  // ----- slave answer side -----
  output reg rspValid,
  output reg rspException,
  output reg [7:0] rspFunc,
  output reg [15:0] rspData,
  output reg [3:0] rspExcCode,
  output reg rspSuppressed,
  output reg restartPulse,
  output reg [7:0] asciiDelim,
  output reg [15:0] diagReg,
  // ----- master error recording -----
  input wire mstValid,
  input wire mstIsWrite,
  input wire mstWriteEnabled,
  input wire mstGotException,
  input wire [3:0] mstExcCode,
  input wire mstLengthBad,
  input wire mstTimeout,
  output reg [3:0] mstWriteErr,
  output reg [3:0] mstReadErr
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [3:0] excFor;
    input known;
    input addrOk;
    input valueOk;
    input wrDis;
    input isWr;
    begin
      if (!known)
        excFor = `MBD_EX_FUNC;
      else if (!addrOk)
        excFor = `MBD_EX_ADDR;
      else if (!valueOk)
        excFor = `MBD_EX_VALUE;
      else if (isWr && wrDis)
        excFor = `MBD_EX_WRPROT;
      else
        excFor = `MBD_EX_NONE;
    end
  endfunction

  function [15:0] padCnt;
    input [CNT_W-1:0] c;
    begin
      padCnt = c[15:0];
    end
  endfunction

  // ----------------------------------------
  // table decode
  // ----------------------------------------
  wire tblKnown;
  wire tblWrite;

  mbd_table_map uMap
  (
    .singleRange(singleRange),
    .funcCode(reqFunc),
    .known(tblKnown),
    .isWrite(tblWrite),
    .isReg(),
    .isInput()
  );

  // ----------------------------------------
  // listen-only state
  // ----------------------------------------
  reg listenOnly_q;
  reg listenOnly_d;

  // ----------------------------------------
  // request interpretation
  // ----------------------------------------
  wire isDiag = (reqFunc == `MBD_FC_DIAG);
  wire isRestart = isDiag && (reqSubCode == `MBD_SUB_RESTART);
  wire take = reqValid && (!listenOnly_q || isRestart);

  reg answer;
  reg sendExc;
  reg [3:0] excCode;
  reg [15:0] ansData;
  reg clearCnt;
  reg doRestart;
  reg setDelim;

  wire [CNT_W-1:0] cntCrc;
  wire [CNT_W-1:0] cntExc;
  wire [CNT_W-1:0] cntMsg;
  wire [CNT_W-1:0] cntNoRsp;
  wire [CNT_W-1:0] cntChar;

  always @*
  begin
    answer = 1'b0;
    sendExc = 1'b0;
    excCode = `MBD_EX_NONE;
    ansData = reqData;
    clearCnt = 1'b0;
    doRestart = 1'b0;
    setDelim = 1'b0;
    listenOnly_d = listenOnly_q;
    if (take && isDiag)
    begin
      answer = 1'b1;
      case (reqSubCode)
        `MBD_SUB_ECHO: ansData = reqData;
        `MBD_SUB_RESTART:
        begin
          if (reqData == `MBD_DATA_ZERO)
            doRestart = 1'b1;
          else if (reqData == `MBD_DATA_CLRLO)
          begin
            doRestart = 1'b1;
            clearCnt = 1'b1;
            listenOnly_d = 1'b0;
          end
          else
          begin
            sendExc = 1'b1;
            excCode = `MBD_EX_VALUE;
          end
        end
        `MBD_SUB_DIAGREG, `MBD_SUB_ZERO0, `MBD_SUB_ZERO1:
          ansData = 16'h0000;
        `MBD_SUB_DELIM: setDelim = 1'b1;
        `MBD_SUB_LISTEN:
        begin
          if (reqData == `MBD_DATA_ZERO)
          begin
            answer = 1'b0;
            listenOnly_d = 1'b1;
          end
          else
          begin
            sendExc = 1'b1;
            excCode = `MBD_EX_VALUE;
          end
        end
        `MBD_SUB_CLRCNT:
        begin
          if (reqData == `MBD_DATA_ZERO)
            clearCnt = 1'b1;
          else
          begin
            sendExc = 1'b1;
            excCode = `MBD_EX_VALUE;
          end
        end
        `MBD_SUB_CRCCNT: ansData = padCnt(cntCrc);
        `MBD_SUB_EXCCNT: ansData = padCnt(cntExc);
        `MBD_SUB_MSGCNT: ansData = padCnt(cntMsg);
        `MBD_SUB_NORSP: ansData = padCnt(cntNoRsp);
        `MBD_SUB_CHARERR: ansData = padCnt(cntChar);
        default:
        begin
          // 000b, 0013, 0014 and all others
          sendExc = 1'b1;
          excCode = `MBD_EX_FUNC;
        end
      endcase
    end
    else if (take)
    begin
      answer = 1'b1;
      // only 00, 01, 02, 03 or 08 can leave this function
      excCode = excFor(tblKnown, reqAddrOk, reqValueOk,
        reqWriteDisabled, tblWrite);
      sendExc = (excCode != `MBD_EX_NONE);
    end
  end

  // ----------------------------------------
  // diagnostic counters
  // ----------------------------------------
  wire excSent = answer && sendExc;
  // an unsupported function or a lost message counts as unanswered
  wire noRsp = evBufferFail || (excSent && excCode == `MBD_EX_FUNC);

  mbd_counter #(.WIDTH(CNT_W)) uCntCrc
  (
    .clock(clock),
    .srst(srst),
    .clear(clearCnt),
    .count(evCrcError),
    .value(cntCrc)
  );

  mbd_counter #(.WIDTH(CNT_W)) uCntExc
  (
    .clock(clock),
    .srst(srst),
    .clear(clearCnt),
    .count(excSent),
    .value(cntExc)
  );

  mbd_counter #(.WIDTH(CNT_W)) uCntMsg
  (
    .clock(clock),
    .srst(srst),
    .clear(clearCnt),
    .count(evGoodMsg),
    .value(cntMsg)
  );

  mbd_counter #(.WIDTH(CNT_W)) uCntNoRsp
  (
    .clock(clock),
    .srst(srst),
    .clear(clearCnt),
    .count(noRsp),
    .value(cntNoRsp)
  );

  mbd_counter #(.WIDTH(CNT_W)) uCntChar
  (
    .clock(clock),
    .srst(srst),
    .clear(clearCnt),
    .count(evCharError),
    .value(cntChar)
  );

  // ----------------------------------------
  // slave answer registers
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (srst)
    begin
      listenOnly_q <= 1'b0;
      rspValid <= 1'b0;
      rspException <= 1'b0;
      rspFunc <= 8'h00;
      rspData <= 16'h0000;
      rspExcCode <= 4'h0;
      rspSuppressed <= 1'b0;
      restartPulse <= 1'b0;
      asciiDelim <= `MBD_DELIM_RST;
      diagReg <= 16'h0000;
    end
    else
    begin
      listenOnly_q <= listenOnly_d;
      rspValid <= answer;
      rspException <= answer && sendExc;
      rspFunc <= reqFunc;
      rspData <= ansData;
      rspExcCode <= excCode;
      // requests dropped while listening, plus the entry request itself
      rspSuppressed <= reqValid && !answer;
      restartPulse <= doRestart;
      if (setDelim)
        asciiDelim <= reqData[15:8];
      diagReg <= 16'h0000;
      diagReg[`MBD_DREG_LISTEN_BIT] <= listenOnly_d;
    end
  end

  // ----------------------------------------
  // master error recording
  // ----------------------------------------
  // priority: local faults first, then the slave's own code
  reg [3:0] mstCode;

  always @*
  begin
    mstCode = `MBD_EX_NONE;
    if (mstIsWrite && !mstWriteEnabled)
      mstCode = `MBD_ME_WRINH;
    else if (mstTimeout)
      mstCode = `MBD_ME_TIMEOUT;
    else if (mstLengthBad)
      mstCode = `MBD_ME_LENGTH;
    else if (mstGotException)
      mstCode = mstExcCode;
  end

  always @(posedge clock)
  begin
    if (srst)
    begin
      mstWriteErr <= 4'h0;
      mstReadErr <= 4'h0;
    end
    else if (mstValid)
    begin
      // a clean transaction returns the field to zero
      if (mstIsWrite)
        mstWriteErr <= mstCode;
      else
        mstReadErr <= mstCode;
    end
  end

endmodule

// ### verilog/mbd_table_map.v
// mbd_table_map.v: maps a function code to a table class and
// access kind, for the separate-table and single-range dialects.
// assumes: purely combinational; inputs come from the same clock.
`timescale 1ns/1ps
`include "mbd_consts.vh"

module mbd_table_map
(
  input wire singleRange,
  input wire [7:0] funcCode,
  output reg known,
  output reg isWrite,
  output reg isReg,
  output reg isInput
)
;

  always @*
  begin
    known = 1'b1;
    isWrite = 1'b0;
    isReg = 1'b0;
    isInput = 1'b0;
    case (funcCode)
      `MBD_FC_RD_OBITS: isInput = 1'b0;
      `MBD_FC_RD_IBITS: isInput = ~singleRange;
      `MBD_FC_RD_OREGS: isReg = 1'b1;
      `MBD_FC_RD_IREGS:
      begin
        isReg = 1'b1;
        isInput = ~singleRange;
      end
      `MBD_FC_WR_OBIT, `MBD_FC_WR_OBITS: isWrite = 1'b1;
      `MBD_FC_WR_OREG, `MBD_FC_WR_OREGS:
      begin
        isWrite = 1'b1;
        isReg = 1'b1;
      end
      default: known = 1'b0;
    endcase
  end

endmodule
